// *** hdl/iof_receiver.sv ***
// Packet receiver: collects packets from the link, answers interrupts,
// returns completion credits and logs every flagged error in APB registers.
// Assumes an APB master on pclk and the framer on the same clock.
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "iof_regs.svh"

module iof_receiver (
  // Clock, reset and enable.
  input logic pclk,
  input logic presetn,
  input logic cen,
  // APB slave.
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Packet delivery.
  output logic pkt_valid,
  output logic [31:0] pkt_hdr,
  output logic [127:0] pkt_payload,
  // Interrupt answer.
  output logic intr_resp_valid,
  output logic intr_resp_accept,
  output logic [15:0] intr_resp_tag,
  // Completion delivery.
  output logic cpl_valid,
  output logic [5:0] cpl_thread,
  // Link from the framer.
  iof_link_if.rx link
);

  iof_pkg::iof_rx_state_e state_q;
  logic [1:0] cnt_q;
  logic [31:0] hdr_q;
  logic intr_q;
  logic [127:0] pay_q;
  logic pkt_valid_q;
  logic intr_valid_q;
  logic intr_accept_q;
  logic [15:0] intr_tag_q;
  logic cpl_valid_q;
  logic [5:0] cpl_thread_q;
  logic [1:0] ctrl_q;
  logic [6:0] err_q;
  logic [31:0] err_log_q;
  logic [15:0] credit_q;
  logic [31:0] pkt_cnt_q;
  logic ready_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Link side decode.
  wire take = link.valid & ready_q;
  wire hdr_take = take & link.first;
  wire pay_take = take & ~link.first & (state_q == iof_pkg::RX_PAY);
  wire stray = take & ~link.first & (state_q == iof_pkg::RX_HDR);
  wire done = pay_take & (cnt_q == `IOF_RX_LAST_CNT);
  wire [15:0] tag = hdr_q[`IOF_HDR_TAG_HI:`IOF_HDR_TAG_LO];
  wire [3:0] hdr_err = hdr_q[`IOF_HDR_TIMEOUT:`IOF_HDR_CTAG_UE];
  wire ecc_bad = iof_pkg::iof_tag_ecc(tag) != hdr_q[`IOF_HDR_ECC_HI:`IOF_HDR_ECC_LO];
  wire pad_bad = tag[`IOF_TAG_PAD_HI:`IOF_TAG_PAD_LO] != `IOF_TAG_PAD_ZERO;
  wire frame_bad = stray | (hdr_take & (state_q == iof_pkg::RX_PAY));
  wire [6:0] err_set = {
    done & ~intr_q & pad_bad,
    done & ecc_bad,
    frame_bad,
    done ? hdr_err : 4'h0
  };
  wire [15:0] credit_ret = (done & ~intr_q) ? (16'h0001 << tag[`IOF_TAG_CREDIT_HI:`IOF_TAG_CREDIT_LO]) : 16'h0000;

  // APB decode; writes land at the edge where pready is seen high.
  wire acc = psel & penable;
  wire wr_now = acc & pwrite & pready_q;
  wire sel_ctrl = paddr == `IOF_REG_CTRL;
  wire sel_err = paddr == `IOF_REG_ERR;
  wire sel_log = paddr == `IOF_REG_ERR_LOG;
  wire sel_cred = paddr == `IOF_REG_CREDIT;
  wire sel_cnt = paddr == `IOF_REG_PKT_CNT;
  wire mapped = sel_ctrl | sel_err | sel_log | sel_cred | sel_cnt;
  wire [6:0] err_clr = (wr_now & sel_err) ? pwdata[6:0] : 7'h00;
  wire [15:0] credit_clm = (wr_now & sel_cred) ? pwdata[15:0] : 16'h0000;
  wire [31:0] rd_mux = sel_ctrl ? {30'h0, ctrl_q} :
                       sel_err ? {25'h0, err_q} :
                       sel_log ? err_log_q :
                       sel_cred ? {16'h0, credit_q} :
                       sel_cnt ? pkt_cnt_q : 32'h0000_0000;

  // Packet assembly; a header in mid-packet restarts the packet.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= iof_pkg::RX_HDR;
      cnt_q <= 2'h0;
      hdr_q <= 32'h0000_0000;
      intr_q <= 1'b0;
      pay_q <= 128'h0;
    end else if (cen) begin
      if (hdr_take) begin
        state_q <= iof_pkg::RX_PAY;
        cnt_q <= 2'h0;
        hdr_q <= link.data;
        intr_q <= link.intr;
      end else if (pay_take) begin
        pay_q <= {pay_q[95:0], link.data};
        cnt_q <= cnt_q + 2'h1;
        if (done) begin
          state_q <= iof_pkg::RX_HDR;
        end
      end
    end
  end

  // Delivery, interrupt answer and completion; reserved bits are ignored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_valid_q <= 1'b0;
      intr_valid_q <= 1'b0;
      intr_accept_q <= 1'b0;
      intr_tag_q <= 16'h0000;
      cpl_valid_q <= 1'b0;
      cpl_thread_q <= 6'h00;
      pkt_cnt_q <= 32'h0000_0000;
    end else if (cen) begin
      pkt_valid_q <= done;
      intr_valid_q <= done & intr_q;
      cpl_valid_q <= done & ~intr_q;
      if (done) begin
        pkt_cnt_q <= pkt_cnt_q + 32'h0000_0001;
        if (intr_q) begin
          intr_tag_q <= tag;
          intr_accept_q <= ctrl_q[`IOF_CTRL_INTR_ACCEPT] & (hdr_err == 4'h0);
        end else begin
          cpl_thread_q <= tag[`IOF_TAG_THREAD_HI:`IOF_TAG_THREAD_LO];
        end
      end
    end
  end

  // Registers: error bits and credits let a hardware set win over a clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `IOF_CTRL_RST;
      err_q <= 7'h00;
      err_log_q <= 32'h0000_0000;
      credit_q <= `IOF_CREDIT_RST;
      ready_q <= 1'b0;
    end else if (cen) begin
      if (wr_now & sel_ctrl) begin
        ctrl_q <= pwdata[1:0];
      end
      err_q <= (err_q & ~err_clr) | err_set;
      if (done && hdr_err != 4'h0) begin
        err_log_q <= hdr_q;
      end
      credit_q <= (credit_q & ~credit_clm) | credit_ret;
      ready_q <= ctrl_q[`IOF_CTRL_LINK_EN];
    end
  end

  // APB answer: one wait cycle, data and error latched with pready.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (cen) begin
      pready_q <= acc & ~pready_q;
      if (acc && !pready_q) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_q <= ~mapped;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pkt_valid = pkt_valid_q;
  assign pkt_hdr = hdr_q;
  assign pkt_payload = pay_q;
  assign intr_resp_valid = intr_valid_q;
  assign intr_resp_accept = intr_accept_q;
  assign intr_resp_tag = intr_tag_q;
  assign cpl_valid = cpl_valid_q;
  assign cpl_thread = cpl_thread_q;
  assign link.ready = ready_q;

endmodule

// *** hdl/iof_regs.svh ***
// Constants shared by both ends of the inbound packet link: header field
// positions, packet shape, receiver register offsets and reset values.
// Assumes nothing of its surroundings; it holds definitions only.
//
// Overview of operation
// - One header word, then four payload words.
// - Header bit 31 flags a timeout.
// - Header bit 30 flags a bad address.
// - Header bit 29 flags an uncorrectable error.
// - Header bit 28 flags uncorrectable tag check bits.
// - Header bits 21:16 carry tag check bits.
// - Header bits 15:0 carry the tag unchanged.
// - Receiver returns interrupt tag with accept/reject.
// - Receiver frees completion credit from tag 12:9.
// - Completion tag 8:0 is zeros then thread id.
// - Payload bytes ascend, four per word, byte0 first.
// - Sender has no registers; errors only in header.
// - Receiver records every error a header flags.
`ifndef IOF_REGS_SVH
`define IOF_REGS_SVH

// Header field positions.
`define IOF_HDR_TIMEOUT 31
`define IOF_HDR_BAD_ADDR 30
`define IOF_HDR_UNCORR 29
`define IOF_HDR_CTAG_UE 28
`define IOF_HDR_RSVD_HI 27
`define IOF_HDR_RSVD_LO 22
`define IOF_HDR_ECC_HI 21
`define IOF_HDR_ECC_LO 16
`define IOF_HDR_TAG_HI 15
`define IOF_HDR_TAG_LO 0
`define IOF_RSVD_ZERO 6'h00

// Tag fields of a completion.
`define IOF_TAG_CREDIT_HI 12
`define IOF_TAG_CREDIT_LO 9
`define IOF_TAG_PAD_HI 8
`define IOF_TAG_PAD_LO 6
`define IOF_TAG_THREAD_HI 5
`define IOF_TAG_THREAD_LO 0
`define IOF_TAG_PAD_ZERO 3'h0

// Packet shape.
`define IOF_PAY_BEATS 4
`define IOF_LAST_BEAT 3'h4
`define IOF_RX_LAST_CNT 2'h3

// Receiver register offsets.
`define IOF_REG_CTRL 12'h000
`define IOF_REG_ERR 12'h004
`define IOF_REG_ERR_LOG 12'h008
`define IOF_REG_CREDIT 12'h00C
`define IOF_REG_PKT_CNT 12'h010

// Receiver control bits and reset values.
`define IOF_CTRL_LINK_EN 0
`define IOF_CTRL_INTR_ACCEPT 1
`define IOF_CTRL_RST 2'h3
`define IOF_CREDIT_RST 16'hFFFF

// Receiver error bits.
`define IOF_ERR_FRAMING 4
`define IOF_ERR_ECC 5
`define IOF_ERR_FORMAT 6

`endif

// *** hdl/iof_pkg.sv ***
// Types and the tag check-bit function shared by both ends of the link.
// Assumes the constants header is on the include path.
`include "iof_regs.svh"

package iof_pkg;

  typedef struct packed {
    logic first;
    logic intr;
    logic [31:0] data;
  } iof_word_s;

  typedef enum {TX_IDLE, TX_SEND} iof_tx_state_e;
  typedef enum {RX_HDR, RX_PAY} iof_rx_state_e;

  // Hamming code over the 16-bit tag with an overall parity bit on top,
  // so a double error is told apart from a single one.
  function automatic logic [5:0] iof_tag_ecc(input logic [15:0] tag);
    logic [4:0] c;
    int k;
    int p;
    int b;
    c = 5'h00;
    k = 0;
    for (p = 3; p < 22; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (b = 0; b < 5; b++) begin
          if (((p >> b) & 1) != 0) begin
            c[b] = c[b] ^ tag[k];
          end
        end
        k++;
      end
    end
    return {^{tag, c}, c};
  endfunction

endpackage

// *** hdl/iof_link_if.sv ***
// The word link between the packet framer and the packet receiver.
// Both ends run on pclk; the framer holds a word until ready is seen high.
`timescale 1ns/1ps

interface iof_link_if (
  input logic pclk
);
  logic valid;
  logic first;
  logic intr;
  logic [31:0] data;
  logic ready;

  modport tx (
    output valid,
    output first,
    output intr,
    output data,
    input ready
  );

  modport rx (
    input valid,
    input first,
    input intr,
    input data,
    output ready
  );
endinterface

// *** hdl/iof_framer.sv ***
// Packet framer: takes one inbound packet at a time from the user side and
// sends it on the link as a header word and four payload words.
// Assumes the receiver on the link runs on the same pclk.
`timescale 1ns/1ps
`include "iof_regs.svh"

module iof_framer (
  // Clock, reset and enable.
  input logic pclk,
  input logic presetn,
  input logic cen,
  // Packet request from the user side.
  input logic req_valid,
  output logic req_ready,
  input logic req_intr,
  input logic timeout_flag,
  input logic bad_address_flag,
  input logic uncorrectable_flag,
  input logic ctag_ue_in,
  input logic [15:0] tag_in,
  input logic [5:0] tag_ecc_in,
  input logic [127:0] payload_in,
  // Status toward the user side.
  output logic busy,
  output logic sent,
  output logic ctag_err,
  // Link toward the receiver.
  iof_link_if.tx link
);

  iof_pkg::iof_tx_state_e state_q;
  iof_pkg::iof_tx_state_e state_d;
  logic [2:0] beat_q;
  logic req_ready_q;
  logic busy_q;
  logic sent_q;
  logic ctag_err_q;
  logic [31:0] hdr_q;
  logic [127:0] pay_q;
  logic intr_q;

  // Two-entry output buffer: the output stage drives the link, the spare
  // catches the word pushed in the cycle the receiver stalls.
  iof_pkg::iof_word_s out_q;
  logic out_valid_q;
  iof_pkg::iof_word_s spare_q;
  logic spare_valid_q;

  // Request acceptance and incoming tag check.
  wire take = req_valid & req_ready_q;
  wire [5:0] tag_ecc_calc = iof_pkg::iof_tag_ecc(tag_in);
  wire [5:0] syndrome = tag_ecc_calc ^ tag_ecc_in;
  // A double error shows as a nonzero syndrome with even overall parity.
  // A single error in the parity bit sets syndrome bit 5 alone and is flagged nowhere; the receiver only sees regenerated check bits.
  wire double_err = (syndrome[4:0] != 5'h00) & ~syndrome[5];
  wire ctag_ue = ctag_ue_in | double_err;

  // Any flagged fault also marks the packet as uncorrectable so that a
  // receiver which looks at bit 29 alone still drops the data.
  wire uncorr = uncorrectable_flag | timeout_flag | bad_address_flag | ctag_ue;

  // The header word. The tag goes out exactly as received; only its check
  // bits are regenerated, which equal the incoming ones whenever the tag
  // arrived clean.
  wire [31:0] hdr_d = {
    timeout_flag,
    bad_address_flag,
    uncorr,
    ctag_ue,
    `IOF_RSVD_ZERO,
    tag_ecc_calc,
    tag_in
  };

  // Payload words in ascending byte order, byte 0 in the top lane.
  wire [31:0] pay_word [`IOF_PAY_BEATS];
  genvar g;
  generate
    for (g = 0; g < `IOF_PAY_BEATS; g++) begin : g_word
      assign pay_word[g] = pay_q[127 - 32 * g -: 32];
    end
  endgenerate

  // Word source of the sequencer.
  wire [1:0] pay_idx = 2'(beat_q - 3'h1);
  wire src_valid = (state_q == iof_pkg::TX_SEND);
  wire src_first = (beat_q == 3'h0);
  wire [31:0] src_data = src_first ? hdr_q : pay_word[pay_idx];
  wire iof_pkg::iof_word_s src_word = '{first: src_first, intr: intr_q, data: src_data};
  // The sequencer stalls only on a full spare entry and never reads the link
  // ready itself, which keeps the ready path one flip-flop deep.
  wire push = src_valid & ~spare_valid_q;
  wire last_push = push & (beat_q == `IOF_LAST_BEAT);
  wire pop = out_valid_q & link.ready;
  wire out_free = ~out_valid_q | pop;

  always_comb begin
    state_d = state_q;
    case (state_q)
      iof_pkg::TX_IDLE: begin
        if (take) begin
          state_d = iof_pkg::TX_SEND;
        end
      end
      iof_pkg::TX_SEND: begin
        if (last_push) begin
          state_d = iof_pkg::TX_IDLE;
        end
      end
      default: begin
        state_d = iof_pkg::TX_IDLE;
      end
    endcase
  end

  // Ready is registered from the next state, so it drops on the edge that
  // accepts a request and rises on the edge that pushes the last word.
  // No request can be taken twice while a packet is still being sequenced.
  // Sequencer: one header then four payload words, no gap of its own.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= iof_pkg::TX_IDLE;
      beat_q <= 3'h0;
      req_ready_q <= 1'b1;
      busy_q <= 1'b0;
    end else if (cen) begin
      state_q <= state_d;
      req_ready_q <= (state_d == iof_pkg::TX_IDLE);
      busy_q <= (state_d == iof_pkg::TX_SEND);
      if (take) begin
        beat_q <= 3'h0;
      end else if (push) begin
        beat_q <= beat_q + 3'h1;
      end
    end
  end

  // Inputs are sampled only on acceptance, so the user side may change them
  // freely while the packet is still on its way.
  // Packet capture at acceptance.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdr_q <= 32'h0000_0000;
      pay_q <= 128'h0;
      intr_q <= 1'b0;
    end else if (cen && take) begin
      hdr_q <= hdr_d;
      pay_q <= payload_in;
      intr_q <= req_intr;
    end
  end

  // Status pulses; the framer keeps no log, faults go out in the header.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sent_q <= 1'b0;
      ctag_err_q <= 1'b0;
    end else if (cen) begin
      sent_q <= last_push;
      ctag_err_q <= take & ctag_ue;
    end
  end

  // The link sees only this stage, so valid, first and data all leave
  // flip-flops and the receiver meets no combinational path.
  // Output stage of the buffer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= '0;
      out_valid_q <= 1'b0;
    end else if (cen && out_free) begin
      if (spare_valid_q) begin
        out_q <= spare_q;
        out_valid_q <= 1'b1;
      end else if (push) begin
        out_q <= src_word;
        out_valid_q <= 1'b1;
      end else begin
        out_valid_q <= 1'b0;
      end
    end
  end

  // A limitation: with two entries a long stall halts the sequencer, and the
  // user side then sees req_ready stay low until the link moves again.
  // Spare entry: filled only while the output is held by a stall.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spare_q <= '0;
      spare_valid_q <= 1'b0;
    end else if (cen) begin
      if (out_free) begin
        spare_valid_q <= 1'b0;
      end else if (push) begin
        spare_q <= src_word;
        spare_valid_q <= 1'b1;
      end
    end
  end

  assign req_ready = req_ready_q;
  assign busy = busy_q;
  assign sent = sent_q;
  assign ctag_err = ctag_err_q;
  assign link.valid = out_valid_q;
  assign link.first = out_q.first;
  assign link.intr = out_q.intr;
  assign link.data = out_q.data;

endmodule

// *** sim/iof_link_sva.sv ***
// Concurrent checks on the word link between the packet framer and receiver.
// Assumes one pclk domain and presetn asynchronous, active low.
`timescale 1ns/1ps

module iof_link_sva (
  // Clock and reset.
  input logic pclk,
  input logic presetn,
  // Link signals.
  input logic valid,
  input logic first,
  input logic intr,
  input logic [31:0] data,
  input logic ready
);
  logic [2:0] left_q;
  logic intr_q;
  wire take = valid && ready;
  wire [2:0] left_d = first ? 3'h4 : left_q - 3'h1;

  // Payload words still owed by the current packet, and its kind.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_q <= 3'h0;
      intr_q <= 1'b0;
    end else if (take) begin
      left_q <= left_d;
      intr_q <= first ? intr : intr_q;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence hdr_take;
    valid && ready && first;
  endsequence
  sequence open_run;
    ready [*3];
  endsequence

  hdr_order_a: assert property (valid && first |-> left_q == 3'h0)
    else $error("header word inside a packet");
  pay_order_a: assert property (valid && !first |-> left_q != 3'h0)
    else $error("payload word without a header");
  pay_soon_a: assert property (hdr_take |-> ##[1:8] (valid && !first))
    else $error("payload late after header");
  burst_run_a: assert property (hdr_take ##1 open_run |-> valid && !first && left_q == 3'h2)
    else $error("payload words not back to back");
  stall_hold_a: assert property (valid && !ready |=> valid && $stable(data) && $stable(first))
    else $error("word changed while stalled");
  rsvd_zero_a: assert property (valid && first |-> data[27:22] == 6'h00)
    else $error("reserved header bits set");
  uncorr_sum_a: assert property (valid && first && (data[31] || data[30] || data[28]) |-> data[29])
    else $error("uncorrectable bit missing");
  kind_hold_a: assert property (valid && !first |-> intr == intr_q)
    else $error("packet kind changed mid packet");
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench: framer and receiver joined by the link interface.
// Assumes the design files and the constants header are compiled first.
`timescale 1ns/1ps

module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic req_valid = 1'b0, req_intr = 1'b0, timeout_flag = 1'b0, bad_address_flag = 1'b0;
  logic uncorrectable_flag = 1'b0, ctag_ue_in = 1'b0;
  logic [15:0] tag_in = 16'h0000;
  logic [5:0] tag_ecc_in = 6'h00;
  logic [127:0] payload_in = 128'h0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, pkt_hdr;
  logic pready, pslverr, req_ready, busy, sent, ctag_err, pkt_valid;
  logic intr_resp_valid, intr_resp_accept, cpl_valid;
  logic [127:0] pkt_payload;
  logic [15:0] intr_resp_tag;
  logic [5:0] cpl_thread;
  int err_total = 0, checked = 0, got_n = 0, sent_n = 0, sent_pulses = 0;
  integer seed = 32'h1FF6;
  logic [32:0] wq[$];
  logic [31:0] hq[$];
  logic [127:0] pq[$];
  logic [16:0] iq[$];
  logic [5:0] cq[$];
  logic [31:0] err_m = 32'h0, log_m = 32'h0, cred_m = 32'h0000FFFF;
  logic acc_m = 1'b1;

  iof_link_if lk (.pclk(pclk));
  iof_framer u_iof_framer (.pclk, .presetn, .cen(1'b1), .req_valid, .req_ready, .req_intr, .timeout_flag,
    .bad_address_flag, .uncorrectable_flag, .ctag_ue_in, .tag_in, .tag_ecc_in, .payload_in, .busy, .sent,
    .ctag_err, .link(lk.tx));
  iof_receiver u_iof_receiver (.pclk, .presetn, .cen(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pkt_valid, .pkt_hdr, .pkt_payload, .intr_resp_valid, .intr_resp_accept,
    .intr_resp_tag, .cpl_valid, .cpl_thread, .link(lk.rx));
  iof_link_sva chk_link (.pclk(pclk), .presetn(presetn), .valid(lk.valid), .first(lk.first),
    .intr(lk.intr), .data(lk.data), .ready(lk.ready));

  initial forever #12.5 pclk = ~pclk;

  task chk(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("checked %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task tmo;
    err_total++;
    $display("[ERR] %0t wait ran out", $time);
    print_verdict();
  endtask

  // Behavioural check bits: Hamming over the tag plus an overall parity bit.
  function automatic logic [5:0] ecc6(input logic [15:0] t);
    logic [4:0] c;
    int k;
    c = 5'h00;
    k = 0;
    for (int p = 3; p < 22; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int b = 0; b < 5; b++) begin
          if (p[b]) c[b] = c[b] ^ t[k];
        end
        k++;
      end
    end
    return {^{t, c}, c};
  endfunction

  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [32:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      if (n == 19) tmo();
    end
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input logic [11:0] a, input logic [32:0] exp);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask

  // Flags f are {timeout, bad address, uncorrectable, tag check}; eflip corrupts the incoming check bits.
  task send(input logic i, input logic [3:0] f, input logic [15:0] t, input logic [5:0] eflip);
    logic [127:0] p;
    logic [31:0] h;
    logic cu;
    p = {$random(seed), $random(seed), $random(seed), $random(seed)};
    cu = f[0] | (eflip == 6'h03);
    h = {f[3], f[2], f[3] | f[2] | f[1] | cu, cu, 6'h00, ecc6(t), t};
    wq.push_back({1'b1, h});
    for (int j = 3; j >= 0; j--) wq.push_back({1'b0, p[j*32 +: 32]});
    hq.push_back(h);
    pq.push_back(p);
    if (i) iq.push_back({acc_m && h[31:28] == 4'h0, t});
    else begin
      cq.push_back(t[5:0]);
      cred_m[t[12:9]] = 1'b1;
      if (t[8:6] != 3'h0) err_m[6] = 1'b1;
    end
    if (h[31:28] != 4'h0) begin
      err_m = err_m | h[31:28];
      log_m = h;
    end
    sent_n++;
    @(posedge pclk);
    req_valid <= 1'b1;
    req_intr <= i;
    {timeout_flag, bad_address_flag, uncorrectable_flag, ctag_ue_in} <= f;
    tag_in <= t;
    tag_ecc_in <= ecc6(t) ^ eflip;
    payload_in <= p;
    for (int n = 0; n < 200; n++) begin
      @(posedge pclk);
      if (req_ready === 1'b1) break;
      if (n == 199) tmo();
    end
    req_valid <= 1'b0;
    @(posedge pclk);
    chk(busy, 1'b1);
    if (!f[0]) chk(ctag_err, eflip == 6'h03);
  endtask

  task wait_rx;
    for (int n = 0; n < 400; n++) begin
      if (got_n == sent_n) return;
      @(posedge pclk);
    end
    tmo();
  endtask

  always @(posedge pclk) begin
    if (presetn && lk.valid === 1'b1 && lk.ready === 1'b1) chk({lk.first, lk.data}, wq.pop_front());
    if (presetn && pkt_valid === 1'b1) begin
      chk(pkt_hdr, hq.pop_front());
      chk(pkt_payload, pq.pop_front());
      got_n++;
    end
    if (presetn && intr_resp_valid === 1'b1) chk({intr_resp_accept, intr_resp_tag}, iq.pop_front());
    if (presetn && cpl_valid === 1'b1) chk(cpl_thread, cq.pop_front());
    if (presetn && sent === 1'b1) sent_pulses++;
  end

  initial begin
    logic [32:0] r;
    logic [15:0] t;
    logic i;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(12'h000, {1'b0, 32'h3});
    rd_chk(12'h004, 33'h0);
    rd_chk(12'h00C, {1'b0, 32'hFFFF});
    rd_chk(12'h010, 33'h0);
    rd_chk(12'h014, {1'b1, 32'h0});
    apb(1'b1, 12'h00C, 32'hFFFF, r);
    cred_m = 32'h0;
    for (int k = 0; k < 24; k++) begin
      // Drain first so the accept setting cannot change under a packet in flight.
      if (k == 12) begin
        wait_rx();
        apb(1'b1, 12'h000, 32'h1, r);
        acc_m = 1'b0;
      end
      // One completion carries a nonzero pad so the receiver's format check is seen to fire.
      i = (k == 0) | ((k != 22) & 1'($random(seed)));
      t = 16'($random(seed));
      if (!i) t[8:6] = (k == 22) ? 3'h5 : 3'h0;
      send(i, k < 16 ? k[3:0] : 4'h0, t, k == 20 ? 6'h03 : (k == 21 ? 6'h20 : 6'h00));
    end
    wait_rx();
    rd_chk(12'h004, {1'b0, err_m});
    rd_chk(12'h008, {1'b0, log_m});
    rd_chk(12'h00C, {1'b0, cred_m});
    rd_chk(12'h010, {1'b0, sent_n[31:0]});
    apb(1'b1, 12'h004, 32'hFFFFFFFF, r);
    rd_chk(12'h004, 33'h0);
    // Receiver stalls: the framer's buffer fills and must then refuse, losing nothing.
    apb(1'b1, 12'h000, 32'h2, r);
    acc_m = 1'b1;
    send(1'b1, 4'h0, 16'hA5C3, 6'h00);
    repeat (20) @(posedge pclk);
    chk({req_ready, got_n == sent_n}, 2'b00);
    apb(1'b1, 12'h000, 32'h3, r);
    wait_rx();
    chk({32'(wq.size()), 32'(iq.size()), 32'(cq.size()), 32'(sent_pulses - sent_n)}, 128'h0);
    chk({busy, req_ready}, 2'b01);
    print_verdict();
  end
endmodule
